//--- rtl/tkp_pd_ctrl.sv
module tkp_pd_ctrl (
	input  wire logic        mclk,
	input  wire logic        srst,
	// Internal register port fed by the serial interface
	input  wire logic        reg_wr_en,
	input  wire logic        reg_rd_en,
	input  wire logic        reg_page,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata,
	output logic             reg_rd_valid,
	// Requests from the touch measurement sequencer
	input  wire logic [3:0]  touch_sw_req,
	input  wire logic        pen_detect_n,
	// Requests from the keypad scanner
	input  wire logic [5:0]  col_drive_req,
	input  wire logic        scan_req,
	input  wire logic        key_irq_req_n,
	input  wire logic        key_load,
	input  wire logic        key_load_sel,
	input  wire logic [15:0] key_load_data,
	// Gated outputs
	output logic      [3:0]  touch_sw_en,
	output logic             pen_touch_interrupt_n,
	output logic      [5:0]  keypad_column_drives,
	output logic             scan_enable,
	output logic             key_interrupt_n,
	output logic      [15:0] key_result_first,
	output logic      [15:0] key_result_second,
	output logic             touch_power_off_bit,
	output logic             keypad_power_off_bit
);

	// ------------------------------------------------------------
	// Register decode
	// ------------------------------------------------------------
	logic        pd_hit;
	logic        touch_off_ff;
	logic        keypad_off_ff;
	logic        nxt_touch_off;
	logic        nxt_keypad_off;

	// Only page 1, address 08h selects the power-down register
	assign pd_hit = (reg_page == tkp_pkg::PD_CTRL_PAGE)
		&& (reg_addr == tkp_pkg::PD_CTRL_ADDR);

	// Next power state; gating below uses it so pins follow on the write edge
	always_comb begin
		nxt_touch_off  = touch_off_ff;
		nxt_keypad_off = keypad_off_ff;
		if (reg_wr_en && pd_hit) begin
			nxt_touch_off  = reg_wdata[tkp_pkg::TOUCH_OFF_POS];
			nxt_keypad_off = reg_wdata[tkp_pkg::KEYPAD_OFF_POS];
		end
	end

	// ------------------------------------------------------------
	// Power-down register
	// ------------------------------------------------------------
	// Touch bit; bits 15:2 have no storage, so writes to them vanish
	always_ff @(posedge mclk) begin
		if (srst) begin
			touch_off_ff <= tkp_pkg::TOUCH_OFF_RST;
		end else begin
			touch_off_ff <= nxt_touch_off;
		end
	end

	// Keypad bit
	always_ff @(posedge mclk) begin
		if (srst) begin
			keypad_off_ff <= tkp_pkg::KEYPAD_OFF_RST;
		end else begin
			keypad_off_ff <= nxt_keypad_off;
		end
	end

	// Status copy of the touch bit for neighbouring blocks
	always_ff @(posedge mclk) begin
		if (srst) begin
			touch_power_off_bit <= tkp_pkg::TOUCH_OFF_RST;
		end else begin
			touch_power_off_bit <= nxt_touch_off;
		end
	end

	// Status copy of the keypad bit; a flop, not a wire, so the pin is clean
	always_ff @(posedge mclk) begin
		if (srst) begin
			keypad_power_off_bit <= tkp_pkg::KEYPAD_OFF_RST;
		end else begin
			keypad_power_off_bit <= nxt_keypad_off;
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	// Read strobe echoed one edge later as the valid flag
	always_ff @(posedge mclk) begin
		if (srst) begin
			reg_rd_valid <= 1'b0;
		end else begin
			reg_rd_valid <= reg_rd_en;
		end
	end

	// Read data is registered and held until the next read
	always_ff @(posedge mclk) begin
		if (srst) begin
			reg_rdata <= tkp_pkg::UNMAPPED_DATA;
		end else if (reg_rd_en && pd_hit) begin
			reg_rdata <= {14'h0, keypad_off_ff, touch_off_ff};
		end else if (reg_rd_en) begin
			reg_rdata <= tkp_pkg::UNMAPPED_DATA;
		end
	end

	// ------------------------------------------------------------
	// Touch screen gating
	// ------------------------------------------------------------
	logic [3:0]  nxt_touch_sw;
	logic        nxt_pen_n;

	// Off wins over every request, so no switch closes on the write edge
	always_comb begin
		nxt_touch_sw = touch_sw_req;
		nxt_pen_n    = pen_detect_n;
		if (nxt_touch_off) begin
			nxt_touch_sw = 4'h0;
			nxt_pen_n    = 1'b1;
		end
	end

	// Switches forced open so no current flows through the panel
	always_ff @(posedge mclk) begin
		if (srst) begin
			touch_sw_en <= tkp_pkg::TOUCH_SW_RST;
		end else begin
			touch_sw_en <= nxt_touch_sw;
		end
	end

	// Pen detection ignored while off; pin parks high
	always_ff @(posedge mclk) begin
		if (srst) begin
			pen_touch_interrupt_n <= tkp_pkg::PEN_IRQ_RST;
		end else begin
			pen_touch_interrupt_n <= nxt_pen_n;
		end
	end

	// ------------------------------------------------------------
	// Keypad gating
	// ------------------------------------------------------------
	logic [5:0]  nxt_columns;
	logic        nxt_scan;
	logic        nxt_key_irq_n;

	// Requests pass again on the very edge that clears the bit
	always_comb begin
		nxt_columns   = col_drive_req;
		nxt_scan      = scan_req;
		nxt_key_irq_n = key_irq_req_n;
		if (nxt_keypad_off) begin
			nxt_columns   = 6'h00;
			nxt_scan      = 1'b0;
			nxt_key_irq_n = 1'b1;
		end
	end

	// Columns low while off; scanner requests pass once powered up
	always_ff @(posedge mclk) begin
		if (srst) begin
			keypad_column_drives <= tkp_pkg::COLUMN_RST;
		end else begin
			keypad_column_drives <= nxt_columns;
		end
	end

	// Scan stops at once; it follows scan_req again on the edge that clears the bit
	always_ff @(posedge mclk) begin
		if (srst) begin
			scan_enable <= tkp_pkg::SCAN_RST;
		end else begin
			scan_enable <= nxt_scan;
		end
	end

	// Interrupt held inactive (high) while the keypad is off
	always_ff @(posedge mclk) begin
		if (srst) begin
			key_interrupt_n <= tkp_pkg::KEY_IRQ_RST;
		end else begin
			key_interrupt_n <= nxt_key_irq_n;
		end
	end

	// ------------------------------------------------------------
	// Key result registers
	// ------------------------------------------------------------
	// Held clear for the whole power-down, so loads there are dropped
	tkp_key_result u_key_result (
		.mclk          (mclk),
		.srst          (srst),
		.clear         (nxt_keypad_off),
		.load          (key_load),
		.load_sel      (key_load_sel),
		.load_data     (key_load_data),
		.result_first  (key_result_first),
		.result_second (key_result_second)
	);

endmodule

//--- rtl/tkp_pkg.sv
package tkp_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam int unsigned DATA_W         = 16;
	localparam int unsigned ADDR_W         = 8;
	localparam logic        PD_CTRL_PAGE   = 1'b1;
	localparam logic [7:0]  PD_CTRL_ADDR   = 8'h08;

	// Field positions in power_down_control
	localparam int unsigned TOUCH_OFF_POS  = 0;
	localparam int unsigned KEYPAD_OFF_POS = 1;

	// Values after reset: both blocks powered up
	localparam logic        TOUCH_OFF_RST  = 1'b0;
	localparam logic        KEYPAD_OFF_RST = 1'b0;

	// Value a read returns for an address that holds nothing
	localparam logic [15:0] UNMAPPED_DATA  = 16'h0000;

	// ------------------------------------------------------------
	// Pin groups
	// ------------------------------------------------------------
	localparam int unsigned TOUCH_SW_N     = 4;
	localparam int unsigned COLUMN_N       = 6;

	// Content of an empty key result register
	localparam logic [15:0] KEY_RESULT_EMPTY = 16'h0000;

	// Output levels while reset is held: switches open, columns low, irqs idle
	localparam logic [3:0]  TOUCH_SW_RST   = 4'h0;
	localparam logic        PEN_IRQ_RST    = 1'b1;
	localparam logic [5:0]  COLUMN_RST     = 6'h00;
	localparam logic        SCAN_RST       = 1'b0;
	localparam logic        KEY_IRQ_RST    = 1'b1;

endpackage

//--- rtl/tkp_key_result.sv
// ------------------------------------------------------------
// Two key result registers, loaded by the scanner
// ------------------------------------------------------------
module tkp_key_result (
	input  wire logic        mclk,
	input  wire logic        srst,
	input  wire logic        clear,
	input  wire logic        load,
	input  wire logic        load_sel,
	input  wire logic [15:0] load_data,
	output logic      [15:0] result_first,
	output logic      [15:0] result_second
);

	// Clear beats load so that no stale key survives a power-down
	always_ff @(posedge mclk) begin
		if (srst || clear) begin
			result_first  <= tkp_pkg::KEY_RESULT_EMPTY;
			result_second <= tkp_pkg::KEY_RESULT_EMPTY;
		end else if (load) begin
			if (load_sel) begin
				result_second <= load_data;
			end else begin
				result_first  <= load_data;
			end
		end
	end

endmodule

//--- dv/tkp_pd_props.sv
module tkp_pd_props (
	input	wire logic		mclk,
	input	wire logic		srst,
	input	wire logic		reg_wr_en,
	input	wire logic		reg_page,
	input	wire logic [7:0]	reg_addr,
	input	wire logic [15:0]	reg_wdata,
	input	wire logic [15:0]	reg_rdata,
	input	wire logic		reg_rd_valid,
	input	wire logic		scan_req,
	input	wire logic [5:0]	col_drive_req,
	input	wire logic [3:0]	touch_sw_en,
	input	wire logic		pen_touch_interrupt_n,
	input	wire logic [5:0]	keypad_column_drives,
	input	wire logic		scan_enable,
	input	wire logic		key_interrupt_n,
	input	wire logic [15:0]	key_result_first,
	input	wire logic [15:0]	key_result_second,
	input	wire logic		touch_power_off_bit,
	input	wire logic		keypad_power_off_bit
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (srst);
	// ------------------------------------------------------------
	// Register side
	// ------------------------------------------------------------
	sequence s_pd_wr;
		reg_wr_en && reg_page && reg_addr == 8'h08;
	endsequence
	a_keypad_bit_store: assert property (s_pd_wr |=> keypad_power_off_bit == $past(reg_wdata[1]))
		else $error("keypad bit not stored");
	a_touch_bit_store: assert property (s_pd_wr |=> touch_power_off_bit == $past(reg_wdata[0]))
		else $error("touch bit not stored");
	a_upper_read_zero: assert property (reg_rd_valid |-> reg_rdata[15:2] == 14'h0)
		else $error("upper bits not zero");
	// ------------------------------------------------------------
	// Gated pins
	// ------------------------------------------------------------
	a_switch_open: assert property (touch_power_off_bit |-> touch_sw_en == 4'h0)
		else $error("switch closed while touch off");
	a_pen_quiet: assert property (touch_power_off_bit |-> pen_touch_interrupt_n)
		else $error("pen interrupt while touch off");
	a_columns_low: assert property (keypad_power_off_bit |-> keypad_column_drives == 6'h00)
		else $error("column driven while keypad off");
	a_scan_halted: assert property (
		keypad_power_off_bit |-> !scan_enable && key_result_first == 16'h0000
			&& key_result_second == 16'h0000)
		else $error("scan or result alive while keypad off");
	// Past reset edge excluded: the register there was forced, not fed
	sequence s_keypad_live;
		!keypad_power_off_bit && !$past(srst);
	endsequence
	a_scan_resumed: assert property (s_keypad_live |-> scan_enable == $past(scan_req))
		else $error("scan not following request");
	a_columns_resumed: assert property (
		s_keypad_live |-> keypad_column_drives == $past(col_drive_req))
		else $error("columns not following request");
	a_key_irq_off: assert property (keypad_power_off_bit |-> key_interrupt_n)
		else $error("key interrupt while keypad off");
endmodule
bind tkp_pd_ctrl tkp_pd_props i_props (
	.mclk                  (mclk),
	.srst                  (srst),
	.reg_wr_en             (reg_wr_en),
	.reg_page              (reg_page),
	.reg_addr              (reg_addr),
	.reg_wdata             (reg_wdata),
	.reg_rdata             (reg_rdata),
	.reg_rd_valid          (reg_rd_valid),
	.scan_req              (scan_req),
	.col_drive_req         (col_drive_req),
	.touch_sw_en           (touch_sw_en),
	.pen_touch_interrupt_n (pen_touch_interrupt_n),
	.keypad_column_drives  (keypad_column_drives),
	.scan_enable           (scan_enable),
	.key_interrupt_n       (key_interrupt_n),
	.key_result_first      (key_result_first),
	.key_result_second     (key_result_second),
	.touch_power_off_bit   (touch_power_off_bit),
	.keypad_power_off_bit  (keypad_power_off_bit)
);

//--- dv/tkp_req_src.sv
module tkp_req_src (
	input	wire logic		mclk,
	output	logic [3:0]	touch_sw_req,
	output	logic		pen_detect_n,
	output	logic [5:0]	col_drive_req,
	output	logic		scan_req,
	output	logic		key_irq_req_n,
	output	logic		key_load,
	output	logic		key_load_sel,
	output	logic [15:0]	key_load_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0]	phase_ff = 2'h0;
	// Scanner and sequencer always ask, so only gating can hold pins off
	assign touch_sw_req = 4'hf;
	assign pen_detect_n = 1'b0;
	assign col_drive_req = 6'h2a;
	assign scan_req = 1'b1;
	assign key_irq_req_n = 1'b0;
	// A load every other cycle, alternating target register
	always @(negedge mclk) phase_ff <= phase_ff + 2'h1;
	assign key_load = phase_ff[0];
	assign key_load_sel = phase_ff[1];
	assign key_load_data = 16'ha5c3;
endmodule

//--- dv/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic	mclk, srst, reg_wr_en, reg_rd_en, reg_page, reg_rd_valid, pen_detect_n, scan_req;
	logic	key_irq_req_n, key_load, key_load_sel, pen_touch_interrupt_n, scan_enable;
	logic	key_interrupt_n, touch_power_off_bit, keypad_power_off_bit;
	logic [3:0]	touch_sw_req, touch_sw_en;
	logic [5:0]	col_drive_req, keypad_column_drives;
	logic [7:0]	reg_addr;
	logic [15:0]	reg_wdata, reg_rdata, key_load_data, key_result_first, key_result_second;
	int	n_fail, tests_run, cyc;
	tkp_pd_ctrl i_dut (
		.mclk                  (mclk),
		.srst                  (srst),
		.reg_wr_en             (reg_wr_en),
		.reg_rd_en             (reg_rd_en),
		.reg_page              (reg_page),
		.reg_addr              (reg_addr),
		.reg_wdata             (reg_wdata),
		.reg_rdata             (reg_rdata),
		.reg_rd_valid          (reg_rd_valid),
		.touch_sw_req          (touch_sw_req),
		.pen_detect_n          (pen_detect_n),
		.col_drive_req         (col_drive_req),
		.scan_req              (scan_req),
		.key_irq_req_n         (key_irq_req_n),
		.key_load              (key_load),
		.key_load_sel          (key_load_sel),
		.key_load_data         (key_load_data),
		.touch_sw_en           (touch_sw_en),
		.pen_touch_interrupt_n (pen_touch_interrupt_n),
		.keypad_column_drives  (keypad_column_drives),
		.scan_enable           (scan_enable),
		.key_interrupt_n       (key_interrupt_n),
		.key_result_first      (key_result_first),
		.key_result_second     (key_result_second),
		.touch_power_off_bit   (touch_power_off_bit),
		.keypad_power_off_bit  (keypad_power_off_bit)
	);
	tkp_req_src i_src (
		.mclk          (mclk),
		.touch_sw_req  (touch_sw_req),
		.pen_detect_n  (pen_detect_n),
		.col_drive_req (col_drive_req),
		.scan_req      (scan_req),
		.key_irq_req_n (key_irq_req_n),
		.key_load      (key_load),
		.key_load_sel  (key_load_sel),
		.key_load_data (key_load_data)
	);
	always #12.5ns mclk = ~mclk;
	// ------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------
	task wrap_up;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("Error at %0t got %h expected %h", $time, g, e);
		end
	endtask
	task wr(input logic p, input logic [7:0] a, input logic [15:0] d);
		@(negedge mclk);
		{reg_wr_en, reg_page, reg_addr, reg_wdata} = {1'b1, p, a, d};
		@(negedge mclk);
		reg_wr_en = 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [15:0] e);
		@(negedge mclk);
		{reg_rd_en, reg_page, reg_addr} = {2'h3, a};
		@(negedge mclk);
		reg_rd_en = 1'b0;
		chk({15'h0, reg_rd_valid}, 16'h0001);
		chk(reg_rdata, e);
	endtask
	// Status bits, switches, pen irq, columns, scan, key irq packed in one word
	task pins(input logic [15:0] e);
		chk({1'b0, touch_power_off_bit, keypad_power_off_bit, touch_sw_en,
			pen_touch_interrupt_n, keypad_column_drives, scan_enable, key_interrupt_n}, e);
	endtask
	// Hang guard; the sequence needs under a hundred cycles
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 1000) begin
			n_fail++;
			wrap_up;
		end
	end
	initial begin
		{mclk, srst, reg_wr_en, reg_rd_en, reg_page, reg_addr, reg_wdata} = {2'h1, 27'h0};
		repeat (5) @(negedge mclk);
		pins(16'h0101);
		srst = 1'b0;
		rd(8'h08, 16'h0000);
		repeat (8) @(negedge mclk);
		pins(16'h1eaa);
		wr(1'b1, 8'h08, 16'hfffe);
		pins(16'h3e01);
		rd(8'h08, 16'h0002);
		chk(key_result_first | key_result_second, 16'h0000);
		wr(1'b1, 8'h08, 16'h0001);
		pins(16'h41aa);
		repeat (8) @(negedge mclk);
		chk(key_result_first & key_result_second, 16'ha5c3);
		wr(1'b0, 8'h08, 16'h0002);
		wr(1'b1, 8'h09, 16'h0002);
		rd(8'h09, 16'h0000);
		rd(8'h08, 16'h0001);
		wr(1'b1, 8'h08, 16'h0003);
		pins(16'h6101);
		rd(8'h08, 16'h0003);
		wrap_up;
	end
endmodule
